// >>> core/adcw_pkg.sv
/*
  Constants of the converter result path: register byte offsets, field
  positions, reset values and conversion timing.
  Assumes a 32-bit APB register bus with one aligned word per register.
*/
package adcw_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADCW_OFS_CONTROL    = 8'h00;
    localparam logic [7:0] ADCW_OFS_RESULT_HI  = 8'h04;
    localparam logic [7:0] ADCW_OFS_RESULT_LO  = 8'h08;
    localparam logic [7:0] ADCW_OFS_UPPER_HI   = 8'h0c;
    localparam logic [7:0] ADCW_OFS_UPPER_LO   = 8'h10;
    localparam logic [7:0] ADCW_OFS_LOWER_HI   = 8'h14;
    localparam logic [7:0] ADCW_OFS_LOWER_LO   = 8'h18;
    localparam logic [7:0] ADCW_OFS_IRQ_STATUS = 8'h1c;
    localparam logic [7:0] ADCW_OFS_IRQ_ENABLE = 8'h20;
    localparam logic [7:0] ADCW_OFS_IRQ_CLEAR  = 8'h24;

    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int ADCW_CTL_JUSTIFY = 0;
    localparam int ADCW_CTL_WINFLAG = 1;
    localparam int ADCW_CTL_BUSY    = 4;
    localparam int ADCW_CTL_DONE    = 5;

    // interrupt status / enable / clear fields
    localparam int ADCW_IRQ_DONE = 0;
    localparam int ADCW_IRQ_WIN  = 1;
    localparam int ADCW_IRQ_BITS = 2;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0]               ADCW_RST_BYTE = 8'h00;
    localparam logic [ADCW_IRQ_BITS-1:0] ADCW_RST_IRQ  = 2'h0;

    // ------------------------------------------------------------
    // conversion timing
    // ------------------------------------------------------------
    localparam int ADCW_CODE_BITS       = 12;
    localparam int ADCW_CONV_SAR_CLOCKS = 16;
    localparam int ADCW_SAR_DIV_DEFAULT = 2;
    localparam int ADCW_CNT_BITS        = 16;

    typedef enum logic [0:0] {
        ADCW_ST_IDLE,
        ADCW_ST_CONVERT
    } adcw_state_t;

endpackage

// >>> core/adcw_format.sv
/*
  Result formatter: places the 12-bit code into the high/low byte pair.
  Assumes the code is two's complement when diff is high.
*/
`timescale 1ns/1ns
module adcw_format
    import adcw_pkg::*;
(
    // conversion code
    input  wire logic [ADCW_CODE_BITS-1:0] code,
    input  wire logic                      diff,
    // format select
    input  wire logic                      justify,
    // formatted bytes
    output logic [7:0]                     high_byte,
    output logic [7:0]                     low_byte
);
    logic [3:0] ext_nibble;

    always_comb begin
        ext_nibble = diff ? {4{code[11]}} : 4'h0;
        if (justify) begin
            high_byte = code[11:4];
            low_byte  = {code[3:0], 4'h0};
        end else begin
            high_byte = {ext_nibble, code[11:8]};
            low_byte  = code[7:0];
        end
    end
endmodule

// >>> core/adcw_window.sv
/*
  Window comparator on the formatted 16-bit result word.
  Assumes result and limits share one justification; diff selects signed compare.
*/
`timescale 1ns/1ns
module adcw_window
    import adcw_pkg::*;
(
    // operands
    input  wire logic [15:0] result_word,
    input  wire logic [15:0] upper_word,
    input  wire logic [15:0] lower_word,
    input  wire logic        diff,
    // outcome
    output logic             hit
);
    logic above_upper;
    logic below_lower;
    logic upper_below_lower;

    always_comb begin
        if (diff) begin
            above_upper       = $signed(result_word) > $signed(upper_word);
            below_lower       = $signed(result_word) < $signed(lower_word);
            upper_below_lower = $signed(upper_word) < $signed(lower_word);
        end else begin
            above_upper       = result_word > upper_word;
            below_lower       = result_word < lower_word;
            upper_below_lower = upper_word < lower_word;
        end
        // inside vs outside chosen purely by how the limits are ordered
        if (upper_below_lower) begin
            hit = above_upper && below_lower;
        end else begin
            hit = above_upper || below_lower;
        end
    end
endmodule

// >>> core/adcw_top.sv
/*
  Converter result path: APB register file, conversion sequencer, result
  formatting, window detection and interrupt status.
  Assumes the converter core holds conv_code/conv_diff valid when the
  conversion time has elapsed after conv_start, and APB signals synchronous to pclk.
*/
// The register offsets and the APB register port were decided locally.
//
// Contract
// - Right-justified: code bits 11..8 go to the high byte low nibble, bits 7..0 to the low byte.
// - Right-justified high nibble is sign copies for differential readings, zero for single-ended.
// - Left-justified: high byte holds bits 11..4, low byte upper nibble bits 3..0, lower nibble zero.
// - Single-ended codes are unsigned over 2^12, differential codes signed over 2^11.
// - Differential codes are two's complement, so minus one step reads all ones right-justified.
// - Every result is compared against both limit words and a hit is signalled.
// - The window hit is latched in the control register for polling or as an interrupt.
// - Inside or outside detection is chosen only by the relative limit values.
// - A conversion takes at least 16 SAR clock periods before result and compare are valid.
`timescale 1ns/1ns
module adcw_top
    import adcw_pkg::*;
#(
    parameter int SAR_DIV = ADCW_SAR_DIV_DEFAULT
)(
    // clock and reset
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    // apb slave
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [7:0]                paddr,
    input  wire logic [31:0]               pwdata,
    output logic [31:0]                    prdata,
    output logic                           pready,
    output logic                           pslverr,
    // converter core
    output logic                           conv_start,
    input  wire logic [ADCW_CODE_BITS-1:0] conv_code,
    input  wire logic                      conv_diff,
    // interrupt
    output logic                           irq
);
    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    localparam int CONV_CYCLES = ADCW_CONV_SAR_CLOCKS * SAR_DIV;
    localparam logic [ADCW_CNT_BITS-1:0] CONV_LAST = ADCW_CNT_BITS'(CONV_CYCLES - 1);

    if (SAR_DIV < 1 || CONV_CYCLES >= (1 << ADCW_CNT_BITS)) begin : g_bad_div
        $error("adcw_top: SAR_DIV out of range");
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    adcw_state_t                 state_reg, state_next;
    logic [ADCW_CNT_BITS-1:0]    count_reg, count_next;
    logic                        start_reg, start_next;
    logic                        justify_reg, justify_next;
    logic                        winflag_reg, winflag_next;
    logic                        done_reg, done_next;
    logic                        diff_reg, diff_next;
    logic [7:0]                  res_hi_reg, res_hi_next;
    logic [7:0]                  res_lo_reg, res_lo_next;
    logic [7:0]                  up_hi_reg, up_hi_next;
    logic [7:0]                  up_lo_reg, up_lo_next;
    logic [7:0]                  lo_hi_reg, lo_hi_next;
    logic [7:0]                  lo_lo_reg, lo_lo_next;
    logic [ADCW_IRQ_BITS-1:0]    ist_reg, ist_next;
    logic [ADCW_IRQ_BITS-1:0]    ien_reg, ien_next;
    logic [31:0]                 rdata_reg, rdata_next;

    // ------------------------------------------------------------
    // formatting and window compare
    // ------------------------------------------------------------
    logic [7:0] fmt_hi;
    logic [7:0] fmt_lo;
    logic       win_hit;

    adcw_format u_format (
        .code      (conv_code),
        .diff      (conv_diff),
        .justify   (justify_reg),
        .high_byte (fmt_hi),
        .low_byte  (fmt_lo)
    );

    adcw_window u_window (
        .result_word (({fmt_hi, fmt_lo})),
        .upper_word  (({up_hi_reg, up_lo_reg})),
        .lower_word  (({lo_hi_reg, lo_lo_reg})),
        .diff        (conv_diff),
        .hit         (win_hit)
    );

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic wr_en;
    logic setup;
    logic mapped;
    logic conv_end;

    always_comb begin
        setup  = psel && !penable;
        wr_en  = psel && penable && pwrite;
        case (paddr)
            ADCW_OFS_CONTROL, ADCW_OFS_RESULT_HI, ADCW_OFS_RESULT_LO,
            ADCW_OFS_UPPER_HI, ADCW_OFS_UPPER_LO, ADCW_OFS_LOWER_HI,
            ADCW_OFS_LOWER_LO, ADCW_OFS_IRQ_STATUS, ADCW_OFS_IRQ_ENABLE,
            ADCW_OFS_IRQ_CLEAR: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
        conv_end = (state_reg == ADCW_ST_CONVERT) && (count_reg == CONV_LAST);
    end

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        state_next   = state_reg;
        count_next   = count_reg;
        start_next   = 1'b0;
        justify_next = justify_reg;
        winflag_next = winflag_reg;
        done_next    = done_reg;
        diff_next    = diff_reg;
        res_hi_next  = res_hi_reg;
        res_lo_next  = res_lo_reg;
        up_hi_next   = up_hi_reg;
        up_lo_next   = up_lo_reg;
        lo_hi_next   = lo_hi_reg;
        lo_lo_next   = lo_lo_reg;
        ist_next     = ist_reg;
        ien_next     = ien_reg;
        rdata_next   = rdata_reg;

        // software writes first, so hardware events below win
        if (wr_en) begin
            case (paddr)
                ADCW_OFS_CONTROL: begin
                    justify_next = pwdata[ADCW_CTL_JUSTIFY];
                    // flags are cleared by writing zero, a one leaves them
                    if (!pwdata[ADCW_CTL_WINFLAG]) begin
                        winflag_next = 1'b0;
                    end
                    if (!pwdata[ADCW_CTL_DONE]) begin
                        done_next = 1'b0;
                    end
                    if (pwdata[ADCW_CTL_BUSY] && state_reg == ADCW_ST_IDLE) begin
                        state_next = ADCW_ST_CONVERT;
                        count_next = '0;
                        start_next = 1'b1;
                    end
                end
                ADCW_OFS_RESULT_HI:  res_hi_next = pwdata[7:0];
                ADCW_OFS_RESULT_LO:  res_lo_next = pwdata[7:0];
                ADCW_OFS_UPPER_HI:   up_hi_next  = pwdata[7:0];
                ADCW_OFS_UPPER_LO:   up_lo_next  = pwdata[7:0];
                ADCW_OFS_LOWER_HI:   lo_hi_next  = pwdata[7:0];
                ADCW_OFS_LOWER_LO:   lo_lo_next  = pwdata[7:0];
                ADCW_OFS_IRQ_ENABLE: ien_next    = pwdata[ADCW_IRQ_BITS-1:0];
                ADCW_OFS_IRQ_CLEAR:  ist_next    = ist_reg & ~pwdata[ADCW_IRQ_BITS-1:0];
                default: ;
            endcase
        end

        // conversion sequencer
        case (state_reg)
            ADCW_ST_IDLE: ;
            ADCW_ST_CONVERT: begin
                if (conv_end) begin
                    state_next  = ADCW_ST_IDLE;
                    res_hi_next = fmt_hi;
                    res_lo_next = fmt_lo;
                    diff_next   = conv_diff;
                    done_next   = 1'b1;
                    ist_next[ADCW_IRQ_DONE] = 1'b1;
                    if (win_hit) begin
                        winflag_next = 1'b1;
                        ist_next[ADCW_IRQ_WIN] = 1'b1;
                    end
                end else begin
                    count_next = count_reg + 1'b1;
                end
            end
            default: state_next = ADCW_ST_IDLE;
        endcase

        // read data captured in the setup cycle, shown in the access cycle
        if (setup) begin
            rdata_next = 32'h0;
            case (paddr)
                ADCW_OFS_CONTROL: begin
                    rdata_next[ADCW_CTL_JUSTIFY] = justify_reg;
                    rdata_next[ADCW_CTL_WINFLAG] = winflag_reg;
                    rdata_next[ADCW_CTL_BUSY]    = (state_reg == ADCW_ST_CONVERT);
                    rdata_next[ADCW_CTL_DONE]    = done_reg;
                end
                ADCW_OFS_RESULT_HI:  rdata_next[7:0] = res_hi_reg;
                ADCW_OFS_RESULT_LO:  rdata_next[7:0] = res_lo_reg;
                ADCW_OFS_UPPER_HI:   rdata_next[7:0] = up_hi_reg;
                ADCW_OFS_UPPER_LO:   rdata_next[7:0] = up_lo_reg;
                ADCW_OFS_LOWER_HI:   rdata_next[7:0] = lo_hi_reg;
                ADCW_OFS_LOWER_LO:   rdata_next[7:0] = lo_lo_reg;
                ADCW_OFS_IRQ_STATUS: rdata_next[ADCW_IRQ_BITS-1:0] = ist_reg;
                ADCW_OFS_IRQ_ENABLE: rdata_next[ADCW_IRQ_BITS-1:0] = ien_reg;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg   <= ADCW_ST_IDLE;
            count_reg   <= '0;
            start_reg   <= 1'b0;
            justify_reg <= 1'b0;
            winflag_reg <= 1'b0;
            done_reg    <= 1'b0;
            diff_reg    <= 1'b0;
            res_hi_reg  <= ADCW_RST_BYTE;
            res_lo_reg  <= ADCW_RST_BYTE;
            up_hi_reg   <= ADCW_RST_BYTE;
            up_lo_reg   <= ADCW_RST_BYTE;
            lo_hi_reg   <= ADCW_RST_BYTE;
            lo_lo_reg   <= ADCW_RST_BYTE;
            ist_reg     <= ADCW_RST_IRQ;
            ien_reg     <= ADCW_RST_IRQ;
            rdata_reg   <= 32'h0;
        end else begin
            state_reg   <= state_next;
            count_reg   <= count_next;
            start_reg   <= start_next;
            justify_reg <= justify_next;
            winflag_reg <= winflag_next;
            done_reg    <= done_next;
            diff_reg    <= diff_next;
            res_hi_reg  <= res_hi_next;
            res_lo_reg  <= res_lo_next;
            up_hi_reg   <= up_hi_next;
            up_lo_reg   <= up_lo_next;
            lo_hi_reg   <= lo_hi_next;
            lo_lo_reg   <= lo_lo_next;
            ist_reg     <= ist_next;
            ien_reg     <= ien_next;
            rdata_reg   <= rdata_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_comb begin
        prdata     = rdata_reg;
        pready     = 1'b1;
        pslverr    = psel && penable && !mapped;
        conv_start = start_reg;
        irq        = |(ist_reg & ien_reg);
    end
endmodule

// >>> tb/adcw_chk.sv
/*
  Port checker for adcw_top, attached by bind.
  Assumes one pclk domain and presetn asynchronous, active low.
*/
`timescale 1ns/1ns
module adcw_chk
    import adcw_pkg::*;
#(
    parameter int SAR_DIV = ADCW_SAR_DIV_DEFAULT
)(
    // clock and reset
    input wire logic                      pclk,
    input wire logic                      presetn,
    // apb
    input wire logic                      psel,
    input wire logic                      penable,
    input wire logic                      pwrite,
    input wire logic [7:0]                paddr,
    input wire logic [31:0]               pwdata,
    input wire logic [31:0]               prdata,
    input wire logic                      pready,
    input wire logic                      pslverr,
    // converter and interrupt
    input wire logic                      conv_start,
    input wire logic [ADCW_CODE_BITS-1:0] conv_code,
    input wire logic                      conv_diff,
    input wire logic                      irq
);
    localparam int CONV = ADCW_CONV_SAR_CLOCKS * SAR_DIV;
    int   cnt_reg;
    int   cnt_next;
    logic acc;
    logic unmapped;
    assign acc      = psel && penable;
    assign unmapped = (paddr[1:0] != 2'h0) || (paddr > ADCW_OFS_IRQ_CLEAR);
    // cycles since the last conversion start, saturating so idle never wraps
    always_comb begin
        cnt_next = (cnt_reg < 1000) ? cnt_reg + 1 : cnt_reg;
        if (conv_start) begin
            cnt_next = 1;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 1000;
        end else begin
            cnt_reg <= cnt_next;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_start_req;
        acc && pwrite && paddr == ADCW_OFS_CONTROL && pwdata[ADCW_CTL_BUSY];
    endsequence
    sequence s_ctl_read;
        acc && !pwrite && paddr == ADCW_OFS_CONTROL;
    endsequence
    a_ready_high: assert property (pready) else $error("pready low");
    a_unmapped_err: assert property (acc && unmapped |-> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped access not refused");
    a_err_access_only: assert property (!acc |-> !pslverr) else $error("pslverr outside access");
    a_start_pulse: assert property (conv_start |=> !conv_start) else $error("start pulse too long");
    a_start_cause: assert property ($rose(conv_start) |-> $past(acc && pwrite && paddr == ADCW_OFS_CONTROL
        && pwdata[ADCW_CTL_BUSY])) else $error("start without request");
    a_start_spacing: assert property (conv_start |-> cnt_reg > CONV)
        else $error("conversion restarted early");
    a_busy_read: assert property (s_ctl_read and (cnt_reg >= 2 && cnt_reg < CONV) |-> prdata[ADCW_CTL_BUSY])
        else $error("busy not shown during conversion");
    a_idle_read: assert property (s_ctl_read and (cnt_reg > CONV + 1) |-> !prdata[ADCW_CTL_BUSY])
        else $error("busy shown while idle");
    a_irq_rise: assert property ($rose(irq) |-> cnt_reg == CONV
        || $past(acc && pwrite && paddr == ADCW_OFS_IRQ_ENABLE))
        else $error("interrupt rose without cause");
    a_irq_fall: assert property ($fell(irq) |-> $past(acc && pwrite))
        else $error("interrupt dropped without software write");
    a_clear_reads_zero: assert property (acc && !pwrite && paddr == ADCW_OFS_IRQ_CLEAR |-> prdata == 32'h0)
        else $error("clear register reads nonzero");
    c_start: cover property (s_start_req ##1 conv_start);
endmodule

bind adcw_top adcw_chk #(.SAR_DIV(SAR_DIV)) u_adcw_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .conv_start(conv_start), .conv_code(conv_code), .conv_diff(conv_diff), .irq(irq)
);

// >>> tb/adcw_core_model.sv
/*
  Behavioural converter core: latches the requested code at conv_start.
  Assumes the bench sets code_in/diff_in before starting a conversion.
*/
`timescale 1ns/1ns
module adcw_core_model
    import adcw_pkg::*;
#(
    parameter int SAR_DIV = ADCW_SAR_DIV_DEFAULT
)(
    // clock, reset and start
    input wire logic                      pclk,
    input wire logic                      presetn,
    input wire logic                      conv_start,
    // requested reading
    input wire logic [ADCW_CODE_BITS-1:0] code_in,
    input wire logic                      diff_in,
    // result to the design
    output logic [ADCW_CODE_BITS-1:0]     conv_code,
    output logic                          conv_diff
);
    localparam int CONV = ADCW_CONV_SAR_CLOCKS * SAR_DIV;
    int                        cnt;
    logic [ADCW_CODE_BITS-1:0] code_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt       <= 1000;
            code_q    <= 12'h000;
            conv_diff <= 1'b0;
        end else if (conv_start) begin
            cnt       <= 1;
            code_q    <= code_in;
            conv_diff <= diff_in;
        end else if (cnt < 1000) begin
            cnt <= cnt + 1;
        end
    end
    // the code is only settled near the end of the sar sequence; garbage otherwise
    assign conv_code = (cnt >= CONV - 4 && cnt <= CONV + 1) ? code_q : ~code_q;
endmodule

// >>> tb/test_adc_result_format_window_detect.sv
/*
  Self-checking bench for adcw_top over APB with a converter core model.
  Assumes zero-wait APB and a start bit in the control register.
*/
`timescale 1ns/1ns
module test_adc_result_format_window_detect;
    import adcw_pkg::*;
    localparam int SAR = 2;
    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        conv_start;
    logic        irq;
    logic [11:0] conv_code;
    logic        conv_diff;
    logic [11:0] code_in = 12'h000;
    logic        diff_in = 1'b0;
    logic [31:0] rq;
    logic        re;
    logic [15:0] up_w;
    logic [15:0] lo_w;
    int          failures  = 0;
    int          tests_run = 0;
    always #5 pclk = ~pclk;
    adcw_top #(.SAR_DIV(SAR)) u_adcw_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .conv_start(conv_start), .conv_code(conv_code), .conv_diff(conv_diff), .irq(irq));
    adcw_core_model #(.SAR_DIV(SAR)) u_adcw_core_model (.pclk(pclk), .presetn(presetn),
        .conv_start(conv_start), .code_in(code_in), .diff_in(diff_in), .conv_code(conv_code),
        .conv_diff(conv_diff));
    // ----
    // bus and compare tasks
    // ----
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no local limit: a missing answer is caught by the watchdog
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rq = prdata;
        re = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic irq_is(input logic exp);
        @(negedge pclk);
        check("irq", {31'h0, irq}, {31'h0, exp});
    endtask
    function automatic logic [15:0] fmt(input logic [11:0] c, input logic d, input logic j);
        return j ? {c, 4'h0} : {{4{d & c[11]}}, c};
    endfunction
    function automatic logic hit(input logic [15:0] r, input logic d);
        logic signed [16:0] rs;
        logic signed [16:0] us;
        logic signed [16:0] ls;
        rs = {d & r[15], r};
        us = {d & up_w[15], up_w};
        ls = {d & lo_w[15], lo_w};
        return (us < ls) ? (rs > us && rs < ls) : (rs > us || rs < ls);
    endfunction
    task automatic limits(input logic [15:0] u, input logic [15:0] l);
        up_w = u;
        lo_w = l;
        apb(1'b1, ADCW_OFS_UPPER_HI, {24'h0, u[15:8]});
        apb(1'b1, ADCW_OFS_UPPER_LO, {24'h0, u[7:0]});
        apb(1'b1, ADCW_OFS_LOWER_HI, {24'h0, l[15:8]});
        apb(1'b1, ADCW_OFS_LOWER_LO, {24'h0, l[7:0]});
    endtask
    task automatic convert(input logic [11:0] c, input logic d, input logic j);
        logic [15:0] e;
        e = fmt(c, d, j);
        code_in = c;
        diff_in = d;
        apb(1'b1, ADCW_OFS_CONTROL, {27'h0, 1'b1, 3'h0, j});
        // a second start while busy must be ignored
        apb(1'b1, ADCW_OFS_CONTROL, {27'h0, 1'b1, 3'h0, j});
        do begin
            apb(1'b0, ADCW_OFS_CONTROL, 32'h0);
        end while (rq[ADCW_CTL_BUSY] !== 1'b0);
        check("conv_done", {31'h0, rq[ADCW_CTL_DONE]}, 32'h1);
        check("window_compare_flag", {31'h0, rq[ADCW_CTL_WINFLAG]}, {31'h0, hit(e, d)});
        apb(1'b0, ADCW_OFS_RESULT_HI, 32'h0);
        check("result_high_byte", rq, {24'h0, e[15:8]});
        apb(1'b0, ADCW_OFS_RESULT_LO, 32'h0);
        check("result_low_byte", rq, {24'h0, e[7:0]});
    endtask
    task automatic end_of_test;
        if (failures == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // ----
    // scenarios
    // ----
    logic [13:0] fcase [9] = '{{12'hfff, 2'b00}, {12'hfff, 2'b01}, {12'h800, 2'b00}, {12'hfff, 2'b10},
        {12'hfff, 2'b11}, {12'h800, 2'b10}, {12'h400, 2'b11}, {12'h001, 2'b10}, {12'h7ff, 2'b10}};
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0);
            check("reset_value", rq, 32'h0);
            check("reset_err", {31'h0, re}, 32'h0);
        end
        for (int i = 1; i < 7; i++) begin
            apb(1'b1, 8'(i * 4), 32'h5a + i);
            apb(1'b0, 8'(i * 4), 32'h0);
            check("rw_value", rq, 32'h5a + i);
        end
        apb(1'b0, 8'h28, 32'h0);
        check("unmapped_err", {31'h0, re}, 32'h1);
        apb(1'b1, 8'h05, 32'hff);
        check("misaligned_err", {31'h0, re}, 32'h1);
        limits(16'h0100, 16'h0800);
        foreach (fcase[i]) convert(fcase[i][13:2], fcase[i][1], fcase[i][0]);
        limits(16'h0800, 16'h0100);
        convert(12'h900, 1'b0, 1'b0);
        convert(12'h400, 1'b0, 1'b0);
        limits(16'h0100, 16'hff00);
        convert(12'hc00, 1'b1, 1'b0);
        convert(12'h000, 1'b1, 1'b0);
        limits(16'h4000, 16'h8000);
        // drop status left by earlier hits so the interrupt below comes from the conversion
        apb(1'b1, ADCW_OFS_IRQ_CLEAR, 32'h3);
        apb(1'b1, ADCW_OFS_IRQ_ENABLE, 32'h2);
        irq_is(1'b0);
        convert(12'h500, 1'b0, 1'b1);
        irq_is(1'b1);
        apb(1'b0, ADCW_OFS_IRQ_STATUS, 32'h0);
        check("irq_status", rq, 32'h3);
        apb(1'b1, ADCW_OFS_IRQ_ENABLE, 32'h0);
        irq_is(1'b0);
        apb(1'b1, ADCW_OFS_IRQ_ENABLE, 32'h2);
        irq_is(1'b1);
        apb(1'b1, ADCW_OFS_IRQ_CLEAR, 32'h3);
        irq_is(1'b0);
        apb(1'b0, ADCW_OFS_IRQ_STATUS, 32'h0);
        check("irq_status_cleared", rq, 32'h0);
        apb(1'b0, ADCW_OFS_CONTROL, 32'h0);
        check("flag_held", {31'h0, rq[ADCW_CTL_WINFLAG]}, 32'h1);
        apb(1'b1, ADCW_OFS_CONTROL, 32'h0);
        apb(1'b0, ADCW_OFS_CONTROL, 32'h0);
        check("flag_cleared", {31'h0, rq[ADCW_CTL_WINFLAG]}, 32'h0);
        end_of_test;
    end
    initial begin
        #500000;
        failures++;
        end_of_test;
    end
endmodule
